// file: core/mal_async_fifo.sv
/*
  dual-clock fifo with gray-coded pointers crossing by two flip-flops.
  assumes depth is a power of two, at least 4; resets are synchronous.
*/
`timescale 1ns/10ps
`default_nettype none
module mal_async_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 16
) (
  // write side
  input wire logic           wr_clk_in,
  input wire logic           wr_rst_n_in,
  mal_stream_if.consumer     wr,
  // read side
  input wire logic           rd_clk_in,
  input wire logic           rd_rst_n_in,
  mal_stream_if.producer     rd
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wbin_reg, wgray_reg, rbin_reg, rgray_reg;
  logic [AW:0]  rg_s1_reg, rg_s2_reg, wg_s1_reg, wg_s2_reg;
  logic [AW:0]  wbin_next, rbin_next;

  assign wbin_next = wbin_reg + 1'b1;
  assign rbin_next = rbin_reg + 1'b1;
  // full when write pointer is one lap ahead of the read pointer
  assign wr.ready = wgray_reg != {~rg_s2_reg[AW:AW-1], rg_s2_reg[AW-2:0]};
  assign rd.valid = rgray_reg != wg_s2_reg;
  assign rd.data  = mem[rbin_reg[AW-1:0]];

  ////////////////////////////////////////////////////////////////////
  // storage has no reset; pointers guard it
  always_ff @(posedge wr_clk_in) begin
    if (wr.valid && wr.ready) begin
      mem[wbin_reg[AW-1:0]] <= wr.data;
    end
  end

  // write pointer and read pointer sync
  always_ff @(posedge wr_clk_in) begin
    if (!wr_rst_n_in) begin
      wbin_reg  <= '0;
      wgray_reg <= '0;
      rg_s1_reg <= '0;
      rg_s2_reg <= '0;
    end else begin
      rg_s1_reg <= rgray_reg;
      rg_s2_reg <= rg_s1_reg;
      if (wr.valid && wr.ready) begin
        wbin_reg  <= wbin_next;
        wgray_reg <= wbin_next ^ (wbin_next >> 1);
      end
    end
  end

  // read pointer and write pointer sync
  always_ff @(posedge rd_clk_in) begin
    if (!rd_rst_n_in) begin
      rbin_reg  <= '0;
      rgray_reg <= '0;
      wg_s1_reg <= '0;
      wg_s2_reg <= '0;
    end else begin
      wg_s1_reg <= wgray_reg;
      wg_s2_reg <= wg_s1_reg;
      if (rd.valid && rd.ready) begin
        rbin_reg  <= rbin_next;
        rgray_reg <= rbin_next ^ (rbin_next >> 1);
      end
    end
  end
endmodule
`default_nettype wire

// file: core/mal_mirror_array.sv
/*
  micromirror array load port: two double-rate high-speed halves with
  continuous training, dual-clock buffering, a double-banked cell array,
  and the slow control link that swaps banks at mirror reset time.
  assumes the controller drives the enable/reset pin, sends training words
  whenever it has no data, and reads the array through the mirror port.
*/
`timescale 1ns/10ps
`default_nettype none
module mal_mirror_array
  import mal_pkg::*;
(
  // core clock and reset
  input  wire logic                  clock_in,
  input  wire logic                  rst_n_in,
  input  wire logic                  array_enable_async_reset_n_in,
  // high-speed halves: index 0 left, 1 right
  input  wire logic [1:0]            hs_clk_in,
  input  wire logic [2*LANES-1:0]    hs_data_in,
  // slow control link
  input  wire logic                  slow_link_clock_in,
  input  wire logic                  slow_link_data_in,
  output logic                       slow_link_readback_a_out,
  output logic                       slow_link_readback_b_out,
  // mirror state read port
  input  wire logic                  mirror_rd_half_in,
  input  wire logic [ROW_W-1:0]      mirror_rd_row_in,
  input  wire logic [COL_W-1:0]      mirror_rd_col_in,
  output logic [WORD_W-1:0]          mirror_word_out,
  // status
  output logic                       border_mirror_band_off_out,
  output logic                       configured_out,
  output logic [1:0]                 overflow_out,
  output logic                       refresh_late_out
);
  logic                      en_s1_reg, en_s2_reg, run_reg;
  logic                      configured_reg, shown_bank_reg;
  logic                      tgl_s1_reg, tgl_s2_reg, tgl_s3_reg;
  logic                      cmd_fire;
  logic [SL_DATA_BITS-1:0]   sl_cmd_word;
  logic                      sl_cmd_toggle;
  logic [3:0]                cmd_op;
  logic [SL_ARG_W-1:0]       cmd_arg;
  logic                      row_load_reg;
  logic [ROW_W-1:0]          row_start_reg;
  logic [1:0]                half_done;
  logic [1:0]                half_first;
  logic                      frame_active_reg;
  logic [1:0]                done_seen_reg;
  logic [15:0]               frame_timer_reg;
  logic [STATUS_W-1:0]       status_word;
  logic [WORD_W-1:0]         rd_q [2];

  ////////////////////////////////////////////////////////////////////
  // enable pin is asynchronous: two flops before use
  always_ff @(posedge clock_in) begin
    en_s1_reg <= array_enable_async_reset_n_in;
    en_s2_reg <= en_s1_reg;
  end

  // core runs only with both resets released
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      run_reg <= 1'b0;
    end else begin
      run_reg <= en_s2_reg;
    end
  end

  // border band has no storage, so it is parked off from the first core clock edge, reset or not
  always_ff @(posedge clock_in) begin
    border_mirror_band_off_out <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////
  // one generate block per half bus; each owns its link clock
  for (genvar h = 0; h < 2; h++) begin : hg
    logic                   lrun_s1_reg, lrun_s2_reg;
    logic [LANES-1:0]       rise_reg, fall_reg, fall_old_reg;
    logic                   phase_reg, push_reg, lost_reg;
    logic [WORD_W-1:0]      word_reg, cand;
    logic                   ovf_s1_reg, ovf_s2_reg;
    logic [COL_W-1:0]       col_reg;
    logic [ROW_W-1:0]       row_reg;
    logic                   done_reg;
    logic [WORD_W-1:0]      cell_mem [1 << ADDR_W];
    logic [WORD_W-1:0]      q_reg;
    mal_stream_if #(.W(WORD_W)) wr_if ();
    mal_stream_if #(.W(WORD_W)) rd_if ();

    // core run level into the link domain
    always_ff @(posedge hs_clk_in[h]) begin
      lrun_s1_reg <= run_reg;
      lrun_s2_reg <= lrun_s1_reg;
    end

    // falling-edge half of each double-rate beat
    always_ff @(negedge hs_clk_in[h]) begin
      fall_reg <= hs_data_in[h*LANES +: LANES];
    end

    // pairing choice set by training: rise then fall, or fall then rise
    assign cand = phase_reg ? {fall_old_reg, rise_reg} : {rise_reg, fall_reg};

    // rising-edge half, pairing, training and push
    always_ff @(posedge hs_clk_in[h]) begin
      if (!lrun_s2_reg) begin
        rise_reg     <= '0;
        fall_old_reg <= '0;
        phase_reg    <= 1'b0;
        push_reg     <= 1'b0;
        word_reg     <= '0;
        lost_reg     <= 1'b0;
      end else begin
        rise_reg     <= hs_data_in[h*LANES +: LANES];
        fall_old_reg <= fall_reg;
        word_reg     <= cand;
        // training words fill every idle beat and are never stored
        push_reg     <= cand != TRAIN_GOOD && cand != TRAIN_SLIP;
        if (cand == TRAIN_SLIP) begin
          phase_reg <= ~phase_reg;
        end
        // no flow control on the pins: a refused word is counted lost
        if (push_reg && !wr_if.ready) begin
          lost_reg <= 1'b1;
        end
      end
    end

    assign wr_if.valid = push_reg;
    assign wr_if.data  = word_reg;

    mal_async_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .wr_clk_in   (hs_clk_in[h]),
      .wr_rst_n_in (lrun_s2_reg),
      .wr          (wr_if),
      .rd_clk_in   (clock_in),
      .rd_rst_n_in (run_reg),
      .rd          (rd_if)
    );

    // drain stalls while the slow link loads a new start row
    assign rd_if.ready = run_reg && !row_load_reg;

    // lost flag is sticky, so a level crossing is enough
    always_ff @(posedge clock_in) begin
      ovf_s1_reg <= lost_reg;
      ovf_s2_reg <= ovf_s1_reg;
    end

    // column and row walk over this half, raster order
    always_ff @(posedge clock_in) begin
      if (!run_reg) begin
        col_reg  <= '0;
        row_reg  <= '0;
        done_reg <= 1'b0;
      end else if (row_load_reg) begin
        col_reg  <= '0;
        row_reg  <= row_start_reg;
        done_reg <= 1'b0;
      end else begin
        done_reg <= 1'b0;
        if (rd_if.valid && rd_if.ready) begin
          if (col_reg == COL_W'(HALF_WORDS - 1)) begin
            col_reg <= '0;
            if (row_reg == ROW_W'(ROWS - 1)) begin
              row_reg  <= '0;
              done_reg <= 1'b1;
            end else begin
              row_reg <= row_reg + 1'b1;
            end
          end else begin
            col_reg <= col_reg + 1'b1;
          end
        end
      end
    end

    // writes go to the hidden bank only; only active cells exist
    always_ff @(posedge clock_in) begin
      if (rd_if.valid && rd_if.ready && configured_reg) begin
        cell_mem[{~shown_bank_reg, row_reg, col_reg}] <= rd_if.data;
      end
    end

    // shown bank read for the mirror port
    always_ff @(posedge clock_in) begin
      q_reg <= cell_mem[{shown_bank_reg, mirror_rd_row_in, mirror_rd_col_in}];
    end

    assign half_done[h]  = done_reg;
    assign half_first[h] = rd_if.valid && rd_if.ready && row_reg == '0 && col_reg == '0;
    assign rd_q[h]       = q_reg;
  end

  ////////////////////////////////////////////////////////////////////
  mal_slow_link u_slow (
    .clk_in         (slow_link_clock_in),
    .run_in         (run_reg),
    .sdata_in       (slow_link_data_in),
    .readback_a_out (slow_link_readback_a_out),
    .readback_b_out (slow_link_readback_b_out),
    .status_in      (status_word),
    .cmd_word_out   (sl_cmd_word),
    .cmd_toggle_out (sl_cmd_toggle)
  );

  // command toggle crosses by two flops, third flop finds the edge; no
  // reset, so an old toggle cannot replay a stale command after a reset
  always_ff @(posedge clock_in) begin
    tgl_s1_reg <= sl_cmd_toggle;
    tgl_s2_reg <= tgl_s1_reg;
    tgl_s3_reg <= tgl_s2_reg;
  end

  assign cmd_fire = tgl_s2_reg ^ tgl_s3_reg;
  // word is stable for a whole frame after the toggle, so safe to take
  assign cmd_op   = sl_cmd_word[SL_OP_LSB +: 4];
  assign cmd_arg  = sl_cmd_word[SL_ARG_W-1:0];

  // command execution
  always_ff @(posedge clock_in) begin
    if (!run_reg) begin
      configured_reg <= 1'b0;
      shown_bank_reg <= 1'b0;
      row_load_reg   <= 1'b0;
      row_start_reg  <= '0;
    end else begin
      row_load_reg <= 1'b0;
      if (cmd_fire) begin
        if (cmd_op == OP_CFG_UP) begin
          configured_reg <= 1'b1;
        end else if (cmd_op == OP_CFG_DOWN) begin
          configured_reg <= 1'b0;
        end else if (cmd_op == OP_MIRROR_RESET && configured_reg) begin
          shown_bank_reg <= ~shown_bank_reg;
        end else if (cmd_op == OP_ROW_START && cmd_arg < SL_ARG_W'(ROWS)) begin
          row_load_reg  <= 1'b1;
          row_start_reg <= cmd_arg[ROW_W-1:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // full-array load timing against the refresh budget
  always_ff @(posedge clock_in) begin
    if (!run_reg) begin
      frame_active_reg <= 1'b0;
      done_seen_reg    <= '0;
      frame_timer_reg  <= '0;
      refresh_late_out <= 1'b0;
    end else begin
      if (|half_first && !frame_active_reg) begin
        frame_active_reg <= 1'b1;
        done_seen_reg    <= '0;
        frame_timer_reg  <= '0;
      end else if (frame_active_reg) begin
        done_seen_reg <= done_seen_reg | half_done;
        if (&(done_seen_reg | half_done)) begin
          frame_active_reg <= 1'b0;
        end
        if (frame_timer_reg != 16'hFFFF) begin
          frame_timer_reg <= frame_timer_reg + 1'b1;
        end
        // sticky: a slow controller shows up until the next reset
        if (frame_timer_reg >= 16'(REFRESH_CYC)) begin
          refresh_late_out <= 1'b1;
        end
      end
    end
  end

  // status for read-back and pins
  assign status_word = {3'h0, refresh_late_out, overflow_out, shown_bank_reg, configured_reg};

  always_ff @(posedge clock_in) begin
    if (!run_reg) begin
      configured_out <= 1'b0;
      overflow_out   <= '0;
    end else begin
      configured_out <= configured_reg;
      overflow_out   <= {hg[1].ovf_s2_reg, hg[0].ovf_s2_reg};
    end
  end

  // mirror port: unconfigured array reads all off
  always_ff @(posedge clock_in) begin
    if (!run_reg || !configured_reg) begin
      mirror_word_out <= '0;
    end else begin
      mirror_word_out <= mirror_rd_half_in ? rd_q[1] : rd_q[0];
    end
  end
endmodule
`default_nettype wire

// file: core/mal_pkg.sv
/*
  constants shared by the micromirror array load port: array geometry,
  link framing, slow-link command encodings and timing counts.
  assumes nothing of its surroundings.
*/
package mal_pkg;
  // array geometry
  localparam int ROWS        = 960;
  localparam int COLS        = 960;
  localparam int BORDER      = 10;
  localparam int WORD_W      = 16;
  localparam int LANES       = 8;
  localparam int HALF_WORDS  = COLS / 2 / WORD_W;
  localparam int ROW_W       = 10;
  localparam int COL_W       = 5;
  localparam int ADDR_W      = 1 + ROW_W + COL_W;
  localparam int FIFO_DEPTH  = 16;
  // training words as seen with good and slipped pairing
  localparam logic [15:0] TRAIN_GOOD = 16'hF00F;
  localparam logic [15:0] TRAIN_SLIP = 16'h0FF0;
  // slow link frame: start bit, then opcode and argument
  localparam int SL_DATA_BITS = 15;
  localparam int SL_OP_LSB    = 11;
  localparam int SL_ARG_W     = 11;
  localparam int STATUS_W     = 8;
  localparam logic [3:0] OP_CFG_UP       = 4'h1;
  localparam logic [3:0] OP_CFG_DOWN     = 4'h2;
  localparam logic [3:0] OP_ROW_START    = 4'h3;
  localparam logic [3:0] OP_MIRROR_RESET = 4'h4;
  // refresh budget, longest time, rounded down
  localparam int CLK_KHZ     = 25000;
  localparam int REFRESH_US  = 100;
  localparam int REFRESH_CYC = REFRESH_US * CLK_KHZ / 1000;
endpackage

// file: core/mal_slow_link.sv
/*
  slow control link receiver and read-back driver, on the link's own clock.
  assumes frames of one start bit plus fifteen bits, msb first, and a
  status word that changes slowly compared with the link clock.
*/
`timescale 1ns/10ps
`default_nettype none
module mal_slow_link
  import mal_pkg::*;
(
  // link side
  input  wire logic                clk_in,
  input  wire logic                run_in,
  input  wire logic                sdata_in,
  output logic                     readback_a_out,
  output logic                     readback_b_out,
  // core side
  input  wire logic [STATUS_W-1:0] status_in,
  output logic [SL_DATA_BITS-1:0]  cmd_word_out,
  output logic                     cmd_toggle_out
);
  typedef enum logic {SL_IDLE, SL_SHIFT} mal_sl_state_t;
  mal_sl_state_t             state_reg;
  logic                      run_s1_reg, run_s2_reg;
  logic [3:0]                bit_cnt_reg;
  logic [SL_DATA_BITS-1:0]   shift_reg;
  logic [STATUS_W-1:0]       st_s1_reg, st_s2_reg;
  logic [2:0]                rb_idx_reg;

  // run level into this domain
  always_ff @(posedge clk_in) begin
    run_s1_reg <= run_in;
    run_s2_reg <= run_s1_reg;
  end

  ////////////////////////////////////////////////////////////////////
  // frame receiver; command word holds until the next frame ends
  always_ff @(posedge clk_in) begin
    if (!run_s2_reg) begin
      state_reg      <= SL_IDLE;
      bit_cnt_reg    <= '0;
      shift_reg      <= '0;
      cmd_word_out   <= '0;
      cmd_toggle_out <= 1'b0;
    end else begin
      case (state_reg)
        SL_IDLE: begin
          bit_cnt_reg <= '0;
          if (sdata_in) begin
            state_reg <= SL_SHIFT;
          end
        end
        SL_SHIFT: begin
          shift_reg   <= {shift_reg[SL_DATA_BITS-2:0], sdata_in};
          bit_cnt_reg <= bit_cnt_reg + 1'b1;
          if (bit_cnt_reg == 4'(SL_DATA_BITS - 1)) begin
            cmd_word_out   <= {shift_reg[SL_DATA_BITS-2:0], sdata_in};
            cmd_toggle_out <= ~cmd_toggle_out;
            state_reg      <= SL_IDLE;
          end
        end
        default: state_reg <= SL_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // status bits cross one by one; they move seldom, so skew is harmless
  always_ff @(posedge clk_in) begin
    st_s1_reg <= status_in;
    st_s2_reg <= st_s1_reg;
  end

  // read-back lines: a carries status lsb first, b marks bit zero
  always_ff @(posedge clk_in) begin
    if (!run_s2_reg) begin
      rb_idx_reg     <= '0;
      readback_a_out <= 1'b0;
      readback_b_out <= 1'b0;
    end else begin
      rb_idx_reg     <= rb_idx_reg + 1'b1;
      readback_a_out <= st_s2_reg[rb_idx_reg];
      readback_b_out <= rb_idx_reg == 3'h0;
    end
  end
endmodule
`default_nettype wire

// file: core/mal_stream_if.sv
/*
  valid/ready word stream between the block's own modules.
  assumes producer holds nothing: a word is taken when valid and ready meet.
*/
`timescale 1ns/10ps
`default_nettype none
interface mal_stream_if #(parameter int W = 16) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport producer (output valid, output data, input ready);
  modport consumer (input valid, input data, output ready);
endinterface
`default_nettype wire

// file: verification/mal_ctrl_model.sv
/*
  display controller model: slow link frames, two ddr half buses with
  training on idle beats, and the enable/reset pin.
  assumes the bench calls its tasks one at a time.
*/
`timescale 1ns/10ps
`default_nettype none
module mal_ctrl_model
  import mal_pkg::*;
(
  // slow link
  output logic        sl_clk_out,
  output logic        sl_data_out,
  input  wire logic   rb_a_in,
  input  wire logic   rb_b_in,
  // high-speed halves and enable pin
  output logic [1:0]  hs_clk_out,
  output logic [15:0] hs_data_out,
  output logic        en_n_out
);
  logic [7:0] bq[2][$];
  logic [7:0] seen;
  int         idx = 0;
  real        hh  = 30.0;

  ////////////////////////////////////////////////////////////////////////
  // training refills whole words, so pairing only moves on a slip
  function automatic logic [7:0] pop(input int h);
    if (bq[h].size() == 0) begin
      bq[h].push_back(TRAIN_GOOD[15:8]);
      bq[h].push_back(TRAIN_GOOD[7:0]);
    end
    return bq[h].pop_front();
  endfunction

  // fresh byte mid-period before every edge, both halves at once
  initial begin
    hs_clk_out  = 2'h0;
    hs_data_out = 16'h0000;
    forever begin
      #(hh / 2.0);
      hs_data_out = {pop(1), pop(0)};
      #(hh / 2.0);
      hs_clk_out = ~hs_clk_out;
    end
  end

  // pin low from power on until the bench lets it go
  initial begin
    sl_clk_out  = 1'b0;
    sl_data_out = 1'b0;
    en_n_out    <= 1'b0;
    clocks(4); // link logic takes its reset only on link clock edges
  end

  // status word gathered at falling edges, b marks bit 0
  always @(negedge sl_clk_out) begin
    idx = rb_b_in ? 0 : idx + 1;
    seen[idx[2:0]] = rb_a_in;
  end

  ////////////////////////////////////////////////////////////////////////
  // one slow clock of 48 ns; clock rests low between calls
  task automatic tick(input logic d);
    sl_data_out = d;
    #24;
    sl_clk_out = 1'b1;
    #24;
    sl_clk_out = 1'b0;
  endtask

  task automatic clocks(input int n);
    repeat (n) tick(1'b0);
  endtask

  // start bit, opcode, argument, msb first, then a gap
  task automatic cmd(input logic [3:0] op, input logic [10:0] arg);
    logic [15:0] f;
    f = {1'b1, op, arg};
    for (int i = 15; i >= 0; i--) begin
      tick(f[i]);
    end
    clocks(4);
  endtask

  // rise byte carries the high half; words come in array order
  task automatic word(input int h, input logic [15:0] w);
    bq[h].push_back(w[15:8]);
    bq[h].push_back(w[7:0]);
  endtask

  // a lone byte shifts the left pairing by one edge
  task automatic slip();
    bq[0].push_back(TRAIN_GOOD[15:8]);
  endtask

  task automatic pin(input logic v);
    en_n_out <= v;
  endtask
endmodule
`default_nettype wire

// file: verification/mal_mirror_array_chk.sv
/*
  port checker for the load port, bound to the top module.
  assumes synchronous active-low reset and an enable pin held several cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module mal_mirror_array_chk
  import mal_pkg::*;
(
  input wire logic              clock_in,
  input wire logic              rst_n_in,
  input wire logic              array_enable_async_reset_n_in,
  input wire logic              slow_link_clock_in,
  input wire logic              slow_link_readback_a_out,
  input wire logic              slow_link_readback_b_out,
  input wire logic [WORD_W-1:0] mirror_word_out,
  input wire logic              border_mirror_band_off_out,
  input wire logic              configured_out,
  input wire logic [1:0]        overflow_out,
  input wire logic              refresh_late_out
);
  logic calm;

  // a cycle out of reset, so sticky bits cleared by it are not misread
  always_ff @(posedge clock_in) begin
    calm <= rst_n_in && array_enable_async_reset_n_in;
  end

  ////////////////////////////////////////////////////////////////////////
  a_border_held: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    border_mirror_band_off_out) else $error("border band not off-tilt");
  a_word_dark: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !configured_out [*4] |-> $past(mirror_word_out) == '0)
    else $error("mirror word shown while unconfigured");
  a_lost_sticky: assert property (@(posedge clock_in)
    disable iff (!rst_n_in || !array_enable_async_reset_n_in || !calm)
    (~overflow_out & $past(overflow_out)) == 2'h0) else $error("overflow bit fell");
  a_late_sticky: assert property (@(posedge clock_in)
    disable iff (!rst_n_in || !array_enable_async_reset_n_in || !calm)
    !$fell(refresh_late_out)) else $error("refresh late fell");
  a_sync_clear: assert property (@(posedge clock_in) !rst_n_in [*2] |=>
    !configured_out && overflow_out == 2'h0 && !refresh_late_out && mirror_word_out == '0)
    else $error("outputs not cleared by reset");
  a_pin_clear: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !array_enable_async_reset_n_in [*4] |=> !configured_out && overflow_out == 2'h0)
    else $error("enable pin did not clear state");
  a_cfg_calm: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    $rose(configured_out) |-> $past(array_enable_async_reset_n_in, 3) && $past(rst_n_in, 3))
    else $error("configured too soon after reset");
  a_mark_period: assert property (@(posedge slow_link_clock_in)
    disable iff (!rst_n_in || !array_enable_async_reset_n_in)
    $rose(slow_link_readback_b_out) |=> !slow_link_readback_b_out [*7] ##1
    slow_link_readback_b_out) else $error("readback mark period wrong");
endmodule

bind mal_mirror_array mal_mirror_array_chk i_mal_mirror_array_chk (
  .clock_in(clock_in), .rst_n_in(rst_n_in),
  .array_enable_async_reset_n_in(array_enable_async_reset_n_in),
  .slow_link_clock_in(slow_link_clock_in),
  .slow_link_readback_a_out(slow_link_readback_a_out),
  .slow_link_readback_b_out(slow_link_readback_b_out),
  .mirror_word_out(mirror_word_out), .configured_out(configured_out),
  .border_mirror_band_off_out(border_mirror_band_off_out),
  .overflow_out(overflow_out), .refresh_late_out(refresh_late_out));
`default_nettype wire

// file: verification/test_mal_mirror_array.sv
/*
  self-checking bench for the load port against the controller model.
  assumes the checker is bound in by its own file.
*/
`timescale 1ns/10ps
`default_nettype none
module test_mal_mirror_array
  import mal_pkg::*;
();
  logic              clock_in = 1'b0;
  logic              rst_n_in = 1'b0;
  logic              en_n;
  logic [1:0]        hs_clk;
  logic [15:0]       hs_data;
  logic              sl_clk;
  logic              sl_data;
  logic              rb_a;
  logic              rb_b;
  logic              rd_half = 1'b0;
  logic [ROW_W-1:0]  rd_row = '0;
  logic [COL_W-1:0]  rd_col = '0;
  logic [WORD_W-1:0] word;
  logic              border;
  logic              cfg;
  logic [1:0]        ovf;
  logic              late;
  int                n_errors = 0;
  int                checks_done = 0;

  // 25 MHz core clock
  initial begin
    forever #20 clock_in = ~clock_in;
  end

  mal_mirror_array i_mal_mirror_array (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .array_enable_async_reset_n_in(en_n),
    .hs_clk_in(hs_clk), .hs_data_in(hs_data), .slow_link_clock_in(sl_clk),
    .slow_link_data_in(sl_data), .slow_link_readback_a_out(rb_a),
    .slow_link_readback_b_out(rb_b), .mirror_rd_half_in(rd_half),
    .mirror_rd_row_in(rd_row), .mirror_rd_col_in(rd_col), .mirror_word_out(word),
    .border_mirror_band_off_out(border), .configured_out(cfg), .overflow_out(ovf),
    .refresh_late_out(late));

  mal_ctrl_model i_model (
    .sl_clk_out(sl_clk), .sl_data_out(sl_data), .rb_a_in(rb_a), .rb_b_in(rb_b),
    .hs_clk_out(hs_clk), .hs_data_out(hs_data), .en_n_out(en_n));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
  endtask

  // shown word comes two cycles after the address
  task automatic rd(input logic h, input logic [COL_W-1:0] c, input logic [15:0] e);
    @(posedge clock_in);
    rd_half <= h;
    rd_col  <= c;
    cyc(3);
    chk(word, e);
  endtask

  // left gets base+i, right its inverse, both halves at once, from row r
  task automatic load(input logic [15:0] base, input int n, input logic [9:0] r);
    i_model.cmd(OP_ROW_START, {1'b0, r});
    for (int i = 0; i < n; i++) begin
      i_model.word(0, base + 16'(i));
      i_model.word(1, ~(base + 16'(i)));
    end
    for (int k = 0; k < 500 && i_model.bq[0].size() > 0; k++) begin
      @(posedge clock_in);
    end
    cyc(20);
    rd_row <= r;
  endtask

  task automatic shown(input logic [15:0] base);
    for (int i = 0; i < 4; i++) begin
      rd(1'b0, 5'(i), base + 16'(i));
      rd(1'b1, 5'(i), ~(base + 16'(i)));
    end
  endtask

  task automatic op(input logic [3:0] code);
    i_model.cmd(code, 11'h000);
    cyc(8);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_load_swap();
    op(OP_CFG_UP);
    chk(16'(cfg), 16'h0001);
    i_model.clocks(16);
    chk(16'(i_model.seen[0]), 16'h0001);
    load(16'hA5C0, 4, 10'h000);
    op(OP_MIRROR_RESET);
    shown(16'hA5C0);
    load(16'h3C10, 4, 10'h000);
    shown(16'hA5C0);
    op(OP_MIRROR_RESET);
    shown(16'h3C10);
  endtask

  // swap refused while unconfigured; shown word dark meanwhile
  task automatic t_refuse();
    op(OP_CFG_DOWN);
    chk(16'(cfg), 16'h0000);
    rd(1'b0, 5'h00, 16'h0000);
    op(OP_MIRROR_RESET);
    op(OP_CFG_UP);
    shown(16'h3C10);
  endtask

  // pairing slipped by one edge must be trained back
  task automatic t_slip();
    i_model.slip();
    cyc(30);
    load(16'h7E01, 4, 10'h001);
    op(OP_MIRROR_RESET);
    shown(16'h7E01);
  endtask

  // both halves burst far faster than the core drains them; the first
  // frame, never finished, then outlives its refresh budget
  task automatic t_overflow();
    i_model.hh = 2.0; // controller retunes its load timing
    load(16'h1200, 40, 10'h000);
    i_model.hh = 30.0;
    chk(16'(ovf), 16'h0003);
    i_model.clocks(16);
    chk(16'(i_model.seen[3:2]), 16'h0003);
    cyc(REFRESH_CYC);
    chk(16'(late), 16'h0001);
  endtask

  task automatic t_pin_reset();
    i_model.pin(1'b0);
    cyc(12);
    i_model.pin(1'b1);
    cyc(6);
    chk(16'({late, border, cfg, ovf}), 16'h0008);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    cyc(8);
    rst_n_in <= 1'b1;
    i_model.pin(1'b1);
    cyc(4);
    chk(16'({late, border, cfg, ovf}), 16'h0008);
    i_model.clocks(12);
    t_load_swap();
    t_refuse();
    t_slip();
    t_overflow();
    t_pin_reset();
    test_done();
  end

  // hang guard, far beyond the expected run of about 130 microseconds
  initial begin
    #2000000;
    n_errors++;
    test_done();
  end
endmodule
`default_nettype wire
